// File: shared/wdtu_defs.vh
// Offsets, field positions, reset values and timing counts for the watchdog timer unit
`ifndef WDTU_DEFS_VH
`define WDTU_DEFS_VH
// APB register byte addresses
`define WDTU_OFS_RESET_CONTROL_REG 12'h000
`define WDTU_OFS_CFG 12'h004
`define WDTU_OFS_CMD 12'h008
`define WDTU_OFS_CNT 12'h00C
// Reset-control register fields
`define WDTU_RC_IDLE 2
`define WDTU_RC_SLEEP 3
`define WDTU_RC_WATCHDOG_TIMEOUT_FLAG 4
`define WDTU_RC_SWEN 5
// Configuration word fields
`define WDTU_CFG_POST_LSB 0
`define WDTU_CFG_POST_MSB 3
`define WDTU_CFG_PRE 4
`define WDTU_CFG_WINDOW_DISABLE 6
`define WDTU_CFG_FIXEN 7
`define WDTU_CFG_RESET 8'hCF
// Command register bits (write-only pulses)
`define WDTU_CMD_CLEAR 0
`define WDTU_CMD_SLEEP 1
`define WDTU_CMD_IDLE 2
// Prescaler ratios
`define WDTU_PRE_SHORT 8'h20
`define WDTU_PRE_LONG 8'h80
// Nominal oscillator rate in Hz and pclk rate in Hz
`define WDTU_LOW_POWER_RC_OSC_HZ 32000
`define WDTU_PCLK_HZ 40000000
`endif

// File: rtl/wdtu_watchdog.v
// Watchdog timer unit: prescaler, postscaler, window check, APB registers
// Function
// - Watchdog runs from low-power RC clock; enabling watchdog enables that oscillator.
// - Prescaler divides by 32 or by 128 per configuration bit.
// - At 32 kHz the prescaler period is about 1 ms or 4 ms.
// - Four-bit postscaler field selects 16 ratios from 1:1 to 1:32768.
// - Counter, prescaler and postscaler clear on every device reset.
// - Completion of any clock switch clears counter and dividers.
// - Entering sleep or idle via power-save instruction clears counter and dividers.
// - Leaving sleep or idle clears counter and dividers.
// - Clear instruction in normal execution clears counter and dividers.
// - Enabled watchdog keeps counting during sleep or idle.
// - Time-out in sleep or idle wakes the core instead of resetting.
// - Sleep and idle flags stay set after wake until software clears.
// - Time-out flag sets on time-out and stays until software clears.
// - Fixed-enable bit set means the watchdog always runs.
// - With fixed-enable clear, watchdog runs only while soft-enable bit set.
// - Soft-enable bit clears on every device reset.
// - In window mode a clear before the last quarter causes a reset.
// - Prescale select one means divide by 128, zero divide by 32.
// - Window-disable one means non-window, zero means window mode.
// - Postscale field codes powers of two, 1111 is 1:32768.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "wdtu_defs.vh"

module wdtu_watchdog #(
  parameter PCLK_HZ = `WDTU_PCLK_HZ,  // System clock rate
  parameter LOW_POWER_RC_OSC_HZ = `WDTU_LOW_POWER_RC_OSC_HZ   // Nominal oscillator rate
) (
  input wire pclk,             // APB clock
  input wire presetn,          // Async reset, active low
  input wire psel,             // APB select
  input wire penable,          // APB enable
  input wire pwrite,           // APB direction
  input wire [11:0] paddr,     // APB byte address
  input wire [31:0] pwdata,    // APB write data
  output reg [31:0] prdata,    // APB read data
  output reg pready,           // APB ready
  output reg pslverr,          // APB error
  input wire low_power_rc_osc_tick,        // Oscillator clock from outside pclk domain
  input wire clk_switch_done,  // Clock switch completed (pin)
  input wire wake_event,       // Other wake source ending power-save (pin)
  output reg low_power_rc_osc_en, // Oscillator enable request
  output reg wdt_reset_req,    // One-cycle device reset request
  output reg wake_req,         // One-cycle core wake request
  output reg core_asleep       // Core in sleep or idle
);

  localparam ST_RUN = 2'h0;
  localparam ST_SLEEP = 2'h1;
  localparam ST_IDLE = 2'h2;

  // Configuration word and status
  reg [7:0] watchdog_config_word;
  reg watchdog_soft_enable;
  reg watchdog_timeout_flag;
  reg sleep_flag;
  reg idle_flag;
  reg [1:0] pstate;
  reg [6:0] pre_cnt;
  reg [15:0] post_cnt;
  reg [2:0] tick_sync;
  reg [1:0] sw_sync;
  reg [1:0] wk_sync;
  reg sw_q;
  reg wk_q;
  reg [1:0] next_pstate;

  // Writes act at the access edge; reads are captured at setup
  // so the read data already stands through the whole access cycle
  wire wen = psel & penable & pwrite & pready;
  wire ren = psel & ~penable & ~pwrite;
  wire [3:0] postscale_select = watchdog_config_word[`WDTU_CFG_POST_MSB:`WDTU_CFG_POST_LSB];
  wire prescale_select = watchdog_config_word[`WDTU_CFG_PRE];
  wire window_disable = watchdog_config_word[`WDTU_CFG_WINDOW_DISABLE];
  wire watchdog_fixed_enable = watchdog_config_word[`WDTU_CFG_FIXEN];
  // Commands are refused outside run: a stopped core cannot issue them
  wire cmd_wr = wen && (paddr == `WDTU_OFS_CMD);
  wire watchdog_clear_instr = cmd_wr && pwdata[`WDTU_CMD_CLEAR] && (pstate == ST_RUN);
  wire power_save_sleep = cmd_wr && pwdata[`WDTU_CMD_SLEEP] && (pstate == ST_RUN);
  wire power_save_idle = cmd_wr && pwdata[`WDTU_CMD_IDLE] && !pwdata[`WDTU_CMD_SLEEP]
                         && (pstate == ST_RUN);
  wire power_save_instr = power_save_sleep | power_save_idle;
  wire wdt_on = watchdog_fixed_enable | watchdog_soft_enable;
  wire tick_rise = tick_sync[1] & ~tick_sync[2];
  wire sw_rise = sw_sync[1] & ~sw_q;
  wire wk_rise = wk_sync[1] & ~wk_q;

  // Divider last-count helper: ratio is a power of two
  function [15:0] wdtu_post_last;
    input [3:0] sel;
    begin
      wdtu_post_last = (16'h0001 << sel) - 16'h0001;
    end
  endfunction

  // Prescaler last count from its ratio; 128 wraps to zero in seven bits
  function [6:0] wdtu_pre_last;
    input [7:0] ratio;
    begin
      wdtu_pre_last = ratio[6:0] - 7'h01;
    end
  endfunction

  // roughly 1 ms or 4 ms
  wire [6:0] pre_last = prescale_select ? wdtu_pre_last(`WDTU_PRE_LONG)
                                        : wdtu_pre_last(`WDTU_PRE_SHORT);
  wire pre_done = tick_rise && (pre_cnt == pre_last);
  wire [15:0] post_last = wdtu_post_last(postscale_select);
  wire timeout = wdt_on && pre_done && (post_cnt == post_last);
  // Elapsed ticks since the last clear, prescale count in the low bits
  wire [22:0] elapsed = prescale_select ? {post_cnt, pre_cnt}
                                        : {2'h0, post_cnt, pre_cnt[4:0]};
  // Full period in ticks; 1:32768 at divide-by-128 still fits 23 bits
  wire [15:0] post_full = post_last + 16'h0001;
  wire [22:0] period = prescale_select ? {post_full, 7'h00} : {2'h0, post_full, 5'h00};
  // Last quarter starts three quarters into the period
  wire [22:0] win_start = period - {2'h0, period[22:2]};
  // early clear check
  // Counting whole ticks keeps 1:1 and 1:2 exact with no special case
  wire early = (elapsed < win_start);
  wire window_violation = watchdog_clear_instr && wdt_on && !window_disable && early;
  wire leave_save = (pstate != ST_RUN) && (timeout || wk_rise);
  // A disabled watchdog holds its dividers at zero, so enabling starts a full period
  wire div_clear = watchdog_clear_instr | sw_rise | power_save_instr | leave_save | !wdt_on;

  // Next power state; a reset request wins over a power-save command
  always @* begin
    next_pstate = pstate;
    case (pstate)
      ST_RUN: begin
        if (timeout || window_violation) begin
          next_pstate = ST_RUN;
        end else if (power_save_sleep) begin
          next_pstate = ST_SLEEP;
        end else if (power_save_idle) begin
          next_pstate = ST_IDLE;
        end
      end
      ST_SLEEP, ST_IDLE: begin
        // Own time-out or an outside event ends power-save
        if (timeout || wk_rise) begin
          next_pstate = ST_RUN;
        end
      end
      // Unused code falls back to run
      default: next_pstate = ST_RUN;
    endcase
  end

  // Synchronisers for pins from outside pclk
  // The oscillator must run below a third of pclk, or rises are lost
  // The third tick stage only feeds the edge detect, never other logic
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_sync <= 3'h0;
      sw_sync <= 2'h0;
      wk_sync <= 2'h0;
      sw_q <= 1'b0;
      wk_q <= 1'b0;
    end else begin
      tick_sync <= {tick_sync[1:0], low_power_rc_osc_tick};
      sw_sync <= {sw_sync[0], clk_switch_done};
      wk_sync <= {wk_sync[0], wake_event};
      sw_q <= sw_sync[1];
      wk_q <= wk_sync[1];
    end
  end

  // A prescale change mid-count may stretch one period; clear after reconfiguring
  // reset clears dividers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= 7'h00;
      post_cnt <= 16'h0000;
    end else if (div_clear || timeout) begin
      pre_cnt <= 7'h00;
      post_cnt <= 16'h0000;
    end else if (tick_rise) begin
      if (pre_done) begin
        pre_cnt <= 7'h00;
        post_cnt <= post_cnt + 16'h0001;
      end else begin
        pre_cnt <= pre_cnt + 7'h01;
      end
    end
  end

  // Power state and wake/reset outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pstate <= ST_RUN;
      wake_req <= 1'b0;
      wdt_reset_req <= 1'b0;
      core_asleep <= 1'b0;
    end else begin
      pstate <= next_pstate;
      wake_req <= 1'b0;
      wdt_reset_req <= 1'b0;
      case (pstate)
        ST_RUN: begin
          if (timeout || window_violation) begin
            wdt_reset_req <= 1'b1;
          end
        end
        ST_SLEEP, ST_IDLE: begin
          if (timeout || wk_rise) begin
            wake_req <= 1'b1;
          end
        end
        default: wdt_reset_req <= 1'b0;
      endcase
      // Asleep follows the state being entered, so it can never sit beside a reset pulse
      core_asleep <= (next_pstate != ST_RUN);
    end
  end

  // Registered so the enable pin never glitches while the config word changes
  // oscillator follows watchdog enable
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_power_rc_osc_en <= 1'b0;
    end else begin
      low_power_rc_osc_en <= wdt_on;
    end
  end

  // Config word stands in for fuses, so software may rewrite it at any time
  // Registers; hardware set wins over software clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_config_word <= `WDTU_CFG_RESET;
      watchdog_soft_enable <= 1'b0;
      watchdog_timeout_flag <= 1'b0;
      sleep_flag <= 1'b0;
      idle_flag <= 1'b0;
    end else begin
      if (wen && paddr == `WDTU_OFS_CFG) begin
        watchdog_config_word <= pwdata[7:0];
      end
      if (wen && paddr == `WDTU_OFS_RESET_CONTROL_REG) begin
        watchdog_soft_enable <= pwdata[`WDTU_RC_SWEN];
        watchdog_timeout_flag <= pwdata[`WDTU_RC_WATCHDOG_TIMEOUT_FLAG];
        sleep_flag <= pwdata[`WDTU_RC_SLEEP];
        idle_flag <= pwdata[`WDTU_RC_IDLE];
      end
      if (timeout || window_violation) begin
        watchdog_timeout_flag <= 1'b1;
      end
      if (power_save_sleep) begin
        sleep_flag <= 1'b1;
      end
      if (power_save_idle) begin
        idle_flag <= 1'b1;
      end
    end
  end

  // APB slave: no wait states, reads captured in setup
  // Unmapped addresses answer with an error; writes there are dropped
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & (paddr != `WDTU_OFS_RESET_CONTROL_REG) & (paddr != `WDTU_OFS_CFG)
                 & (paddr != `WDTU_OFS_CMD) & (paddr != `WDTU_OFS_CNT);
      if (ren) begin
        case (paddr)
          `WDTU_OFS_RESET_CONTROL_REG: prdata <= {26'h0, watchdog_soft_enable, watchdog_timeout_flag,
                                     sleep_flag, idle_flag, 2'h0};
          `WDTU_OFS_CFG: prdata <= {24'h0, watchdog_config_word};
          `WDTU_OFS_CNT: prdata <= {pre_cnt, 9'h000, post_cnt};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // wdtu_watchdog

// File: testbench/wdtu_props.sv
// Checker for the watchdog unit bus and event ports
`timescale 1ns/1ps
module wdtu_props (
  input wire pclk, // Clock
  input wire presetn, // Reset
  input wire psel, // Select
  input wire penable, // Enable
  input wire pwrite, // Write
  input wire [11:0] paddr, // Address
  input wire [31:0] pwdata, // Data
  input wire pready, // Ready
  input wire pslverr, // Error
  input wire low_power_rc_osc_en, // Osc on
  input wire wdt_reset_req, // Reset pulse
  input wire wake_req, // Wake pulse
  input wire core_asleep // Asleep
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Setup phase and a completed write
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wr(a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence
  a_ready_next: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_unmapped: assert property (s_setup ##0 (paddr > 12'h00C) |=> pslverr)
    else $error("no error on unmapped address");
  a_reset_pulse: assert property (wdt_reset_req |=> !wdt_reset_req)
    else $error("reset request too long");
  a_wake_pulse: assert property (wake_req |=> !wake_req)
    else $error("wake request too long");
  a_sleep_no_reset: assert property (core_asleep |-> !wdt_reset_req)
    else $error("reset while asleep");
  a_soft_osc: assert property (s_wr(12'h000) ##0 pwdata[5] |=> ##[0:2] low_power_rc_osc_en)
    else $error("soft enable left oscillator off");
  a_sleep_enter: assert property (s_wr(12'h008) ##0 (pwdata[1] && !core_asleep)
    |=> ##[0:2] core_asleep)
    else $error("sleep not entered");
endmodule // wdtu_props

bind wdtu_watchdog wdtu_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .low_power_rc_osc_en, .wdt_reset_req, .wake_req, .core_asleep);

// File: testbench/testbench.sv
// Self-checking bench for the watchdog timer unit
`timescale 1ns/1ps
module testbench;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg low_power_rc_osc = 1'b0;
  reg sw = 1'b0;
  reg wev = 1'b0;
  reg [2:0] div = 3'h0;
  reg [31:0] rd;
  reg hr, hw, er;
  reg [19:0] rows [0:3];
  integer num_errors = 0;
  integer cmp_count = 0;
  integer n, i;
  wire [31:0] prdata;
  wire pready, pslverr, osc, rst, wake, slp;
  wdtu_watchdog u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .low_power_rc_osc_tick(low_power_rc_osc), .clk_switch_done(sw), .wake_event(wev),
    .low_power_rc_osc_en(osc), .wdt_reset_req(rst), .wake_req(wake), .core_asleep(slp));
  // Clock, 25 ns period
  always #12.5 pclk = ~pclk;
  // Oscillator stand-in, eight cycles a period, slower than pclk/3
  always @(posedge pclk) begin
    div <= div + 3'h1;
    low_power_rc_osc <= div[2];
  end
  task chk(input string nm, input [31:0] s, input [31:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (s !== e) begin
        num_errors = num_errors + 1;
        $display("mismatch %s exp %h seen %h", nm, e, s);
      end
    end
  endtask
  // One transfer; held until ready is sampled high
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
        @(posedge pclk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // Count oscillator rises until a reset or wake pulse, bounded
  task wt(input integer lim);
    reg p;
    begin
      n = 0;
      hr = 1'b0;
      hw = 1'b0;
      p = low_power_rc_osc;
      while (!(hr || hw) && n < lim) begin
        @(posedge pclk);
        hr = rst === 1'b1;
        hw = wake === 1'b1;
        n = n + (low_power_rc_osc && !p);
        p = low_power_rc_osc;
      end
    end
  endtask
  // Synchroniser lag allows one rise either way
  task tk(input integer e, input r);
    begin
      chk("ticks", {31'h0, n >= e - 1 && n <= e + 1}, 32'h1);
      chk("rst", {31'h0, hr}, {31'h0, r});
    end
  endtask
  task final_report;
    begin
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    rows[0] = {8'hC0, 12'h020};
    rows[1] = {8'hD0, 12'h080};
    rows[2] = {8'hC1, 12'h040};
    rows[3] = {8'hC3, 12'h100};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h000, 32'h0);
    chk("reset_control_reg", rd, 32'h0);
    apb(0, 12'h004, 32'h0);
    chk("cfg", rd, 32'h0000_00CF);
    apb(0, 12'h010, 32'h0);
    chk("unmapped", rd, 32'h0);
    chk("unmapped_err", {31'h0, er}, 32'h1);
    // Timeout period per prescale and postscale setting
    for (i = 0; i < 4; i = i + 1) begin
      apb(1, 12'h004, {24'h0, rows[i][19:12]});
      apb(1, 12'h008, 32'h1);
      wt(600);
      tk(rows[i][11:0], 1'b1);
    end
    apb(0, 12'h000, 32'h0);
    chk("flag", rd & 32'h10, 32'h10);
    apb(1, 12'h000, 32'h0);
    apb(0, 12'h000, 32'h0);
    chk("flag_clr", rd, 32'h0);
    // Soft enable with fixed enable off
    apb(1, 12'h004, 32'h40);
    repeat (2) @(posedge pclk);
    chk("osc_off", {31'h0, osc}, 32'h0);
    apb(1, 12'h000, 32'h20);
    repeat (2) @(posedge pclk);
    chk("osc_on", {31'h0, osc}, 32'h1);
    apb(1, 12'h008, 32'h1);
    wt(100);
    tk(32, 1'b1);
    apb(1, 12'h000, 32'h0);
    wt(40);
    chk("soft_off", {31'h0, hr}, 32'h0);
    // Timeout in sleep wakes the core, idle woken by event
    apb(1, 12'h004, 32'hC0);
    apb(1, 12'h000, 32'h0);
    apb(1, 12'h008, 32'h2);
    // Asleep is launched at the command's access edge; look one edge later
    @(posedge pclk);
    chk("asleep", {31'h0, slp}, 32'h1);
    wt(100);
    tk(32, 1'b0);
    chk("wake", {31'h0, hw}, 32'h1);
    apb(0, 12'h000, 32'h0);
    chk("slp_flag", rd & 32'h18, 32'h18);
    apb(1, 12'h008, 32'h4);
    apb(0, 12'h000, 32'h0);
    chk("idl_flag", rd & 32'h1C, 32'h1C);
    wev <= 1'b1;
    wt(3);
    chk("wake_ev", {31'h0, hw & ~slp}, 32'h1);
    wev <= 1'b0;
    // Clock switch restarts the count
    apb(1, 12'h008, 32'h1);
    wt(16);
    sw <= 1'b1;
    wt(100);
    tk(32, 1'b1);
    // Window mode: early clear resets, late clear does not
    sw <= 1'b0;
    apb(1, 12'h004, 32'h81);
    sw <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1, 12'h008, 32'h1);
    wt(2);
    chk("early", {31'h0, hr}, 32'h1);
    sw <= 1'b0;
    wt(2);
    sw <= 1'b1;
    wt(52);
    apb(1, 12'h008, 32'h1);
    wt(2);
    chk("late", {31'h0, hr}, 32'h0);
    // Clear past half but before the last quarter is still early
    wt(40);
    apb(1, 12'h008, 32'h1);
    wt(2);
    chk("mid", {31'h0, hr}, 32'h1);
    // Second reset in mid-run
    apb(1, 12'h000, 32'h20);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h00C, 32'h0);
    chk("cnt_rst", rd, 32'h0);
    apb(0, 12'h000, 32'h0);
    chk("rcon2", rd, 32'h0);
    chk("osc_fix", {31'h0, osc}, 32'h1);
    final_report;
  end
  // Hang guard
  initial begin
    #500000;
    num_errors = num_errors + 1;
    final_report;
  end
endmodule // testbench
